// ### core/epi_pkg.sv
// Package of register map, field positions and encodings for the external pin interrupt unit.
package epi_pkg;

  // Register offsets on the plain register port (chosen map, word per register).
  localparam logic [3:0] ADDR_SENSE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h1;
  localparam logic [3:0] ADDR_IRQ_FLAGS  = 4'h2;
  localparam logic [3:0] ADDR_CORE_CTRL  = 4'h3;
  localparam logic [3:0] ADDR_EVT_STATUS = 4'h4;
  localparam logic [3:0] ADDR_EVT_MASK   = 4'h5;
  localparam logic [3:0] ADDR_PIN_STATE  = 4'h6;

  // Field positions.
  localparam int CH0_SENSE_LSB = 0;
  localparam int CH1_SENSE_LSB = 2;
  localparam int CH0_EN_BIT    = 6;
  localparam int CH1_EN_BIT    = 7;
  localparam int CH0_FLAG_BIT  = 6;
  localparam int CH1_FLAG_BIT  = 7;
  localparam int GIE_BIT       = 0;

  // Reset values.
  localparam logic [7:0] SENSE_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] IRQ_FLAGS_RST  = 8'h00;
  localparam logic [7:0] CORE_CTRL_RST  = 8'h00;
  localparam logic [7:0] EVT_MASK_RST   = 8'h00;

  // Sense modes of each two-bit field.
  typedef enum logic [1:0] {
    EPI_SENSE_LOW    = 2'h0,
    EPI_SENSE_ANY    = 2'h1,
    EPI_SENSE_FALL   = 2'h2,
    EPI_SENSE_RISE   = 2'h3
  } epi_sense_e;

  // Wake sampler states.
  typedef enum logic [1:0] {
    EPI_WK_IDLE,
    EPI_WK_SAMPLE2,
    EPI_WK_STARTUP
  } epi_wake_e;

  // Start-up length in watchdog ticks before wake completes.
  localparam logic [7:0] STARTUP_TICKS = 8'h04;

endpackage

// ### core/epi_unit.sv
// External pin interrupt unit: two sensed pins, flags, enables, wake sampler and register port.
//
// Functional notes
// - Pins sensed even when driven as outputs.
// - Low level requests every cycle pin low.
// - Edge detection clocked by the I/O clock.
// - Low level detection works without I/O clock.
// - Power-down wake samples level twice on watchdog.
// - Level gone before start-up: wake, no interrupt.
// - Request needs global and channel enable set.
// - Pin sampled first; longer-than-cycle pulses detected.
// - Channel-1 sense field is control bits 3:2.
// - Channel-0 sense field is control bits 1:0.
// - Enables at bits 7 and 6; own vectors.
// - Events set pending flags bits 7 and 6.
// - Flag clears on vector entry or write-one.
// - Level mode flag always reads cleared.
`timescale 1ns/1ps
module epi_unit (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Watchdog oscillator tick and power-down indication.
  input  wire logic       wdt_tick,
  input  wire logic       power_down,
  // Interrupt pins, each as input, output value and output enable.
  input  wire logic       ext_irq0_line_i,
  output logic            ext_irq0_line_o,
  output logic            ext_irq0_line_oe,
  input  wire logic       ext_irq1_line_i,
  output logic            ext_irq1_line_o,
  output logic            ext_irq1_line_oe,
  // Register port.
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Core side: requests and vector entry acknowledges.
  output logic            irq0_req,
  output logic            irq1_req,
  input  wire logic       irq0_ack,
  input  wire logic       irq1_ack,
  output logic            wake_up,
  output logic            irq
);

  logic [7:0]       sense_ctrl_r;
  logic [7:0]       irq_enable_r;
  logic [1:0]       pend_r;
  logic [1:0]       pend_nxt;
  logic [7:0]       core_ctrl_r;
  logic [1:0]       evt_status_r;
  logic [1:0]       evt_mask_r;
  logic [1:0]       evt_set;
  logic [1:0]       sync1_r;
  logic [1:0]       sync2_r;
  logic [1:0]       prev_r;
  logic [1:0]       edge_hit;
  logic [1:0]       level_mode;
  logic [1:0]       level_low;
  logic [1:0]       cond;
  logic [1:0]       ch_en;
  logic [1:0]       ack;
  logic [1:0]       w1c;
  logic [7:0]       rdata_nxt;
  logic [7:0]       rdata_r;
  logic [1:0]       wk_s1_r;
  logic [1:0]       wk_s2_r;
  logic [7:0]       wk_cnt_r;
  logic             wake_r;
  epi_pkg::epi_wake_e wk_state_r;
  logic [1:0]       pin_raw;
  logic [1:0]       pin_drv;
  logic [1:0]       pin_oe;
  logic             gie;
  logic             wr_sense;
  logic             wr_enable;
  logic             wr_flags;
  logic             wr_core;
  logic             wr_status;
  logic             wr_mask;
  logic             wr_pin;
  logic [1:0]       status_w1c;
  logic [1:0]       evt_status_nxt;
  logic [1:0]       flags_view;
  logic [7:0]       rd_sense;
  logic [7:0]       rd_enable;
  logic [7:0]       rd_flags;
  logic [7:0]       rd_core;
  logic [7:0]       rd_status;
  logic [7:0]       rd_mask;
  logic [7:0]       rd_pins;
  logic             wake_cand;
  epi_pkg::epi_wake_e wk_state_nxt;
  logic [7:0]       wk_cnt_nxt;
  logic             wake_nxt;

  // Returns the two-bit sense field of a channel.
  function automatic logic [1:0] sense_of(input logic [7:0] ctrl, input int lsb);
    sense_of = ctrl[lsb +: 2];
  endfunction

  // Decides whether a synchronised sample pair is an event for a sense mode.
  function automatic logic edge_match(input logic [1:0] mode, input logic cur, input logic prv);
    case (mode)
      epi_pkg::EPI_SENSE_ANY:  edge_match = cur ^ prv;
      epi_pkg::EPI_SENSE_FALL: edge_match = prv & ~cur;
      epi_pkg::EPI_SENSE_RISE: edge_match = cur & ~prv;
      default:                 edge_match = 1'b0;
    endcase
  endfunction

  // True when the write strobe addresses the given register.
  function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  // The pin value read back is the pad level, so a driven output still triggers.
  assign pin_raw = {ext_irq1_line_i, ext_irq0_line_i};

  // Software may drive the pins through the pin state register to force an interrupt.
  assign ext_irq0_line_o  = pin_drv[0];
  assign ext_irq1_line_o  = pin_drv[1];
  assign ext_irq0_line_oe = pin_oe[0];
  assign ext_irq1_line_oe = pin_oe[1];

  assign gie   = core_ctrl_r[epi_pkg::GIE_BIT];
  assign ch_en = {irq_enable_r[epi_pkg::CH1_EN_BIT], irq_enable_r[epi_pkg::CH0_EN_BIT]};
  assign ack   = {irq1_ack, irq0_ack};

  assign level_mode[0] = sense_of(sense_ctrl_r, epi_pkg::CH0_SENSE_LSB) == epi_pkg::EPI_SENSE_LOW;
  assign level_mode[1] = sense_of(sense_ctrl_r, epi_pkg::CH1_SENSE_LSB) == epi_pkg::EPI_SENSE_LOW;

  // Edges compare the synchronised sample with the one before it.
  assign edge_hit[0] = edge_match(sense_of(sense_ctrl_r, epi_pkg::CH0_SENSE_LSB), sync2_r[0], prev_r[0]);
  assign edge_hit[1] = edge_match(sense_of(sense_ctrl_r, epi_pkg::CH1_SENSE_LSB), sync2_r[1], prev_r[1]);

  // Low level uses the synchronised level while clocked; the wake sampler covers the stopped-clock case.
  assign level_low = level_mode & ~sync2_r;

  assign w1c = wr_flags ?
               {reg_wdata[epi_pkg::CH1_FLAG_BIT], reg_wdata[epi_pkg::CH0_FLAG_BIT]} : 2'h0;

  // A new edge wins over a clear in the same cycle; level mode holds the flag cleared.
  assign pend_nxt = (edge_hit | (pend_r & ~w1c & ~ack)) & ~level_mode;

  assign cond     = pend_r | level_low;
  assign irq0_req = cond[0] & ch_en[0] & gie;
  assign irq1_req = cond[1] & ch_en[1] & gie;

  assign evt_set = edge_hit | level_low;
  assign irq     = |(evt_status_r & evt_mask_r);
  assign wake_up = wake_r;

  // Write decode, one strobe per register.
  assign wr_sense  = wr_hit(reg_wr, reg_addr, epi_pkg::ADDR_SENSE_CTRL);
  assign wr_enable = wr_hit(reg_wr, reg_addr, epi_pkg::ADDR_IRQ_ENABLE);
  assign wr_flags  = wr_hit(reg_wr, reg_addr, epi_pkg::ADDR_IRQ_FLAGS);
  assign wr_core   = wr_hit(reg_wr, reg_addr, epi_pkg::ADDR_CORE_CTRL);
  assign wr_status = wr_hit(reg_wr, reg_addr, epi_pkg::ADDR_EVT_STATUS);
  assign wr_mask   = wr_hit(reg_wr, reg_addr, epi_pkg::ADDR_EVT_MASK);
  assign wr_pin    = wr_hit(reg_wr, reg_addr, epi_pkg::ADDR_PIN_STATE);

  // Sticky event status: a new event wins over a write-one clear in the same cycle.
  assign status_w1c     = wr_status ? reg_wdata[1:0] : 2'h0;
  assign evt_status_nxt = evt_set | (evt_status_r & ~status_w1c);

  // Register views for the read multiplexer. A flag left over from edge mode is hidden at once.
  assign flags_view = pend_r & ~level_mode;
  assign rd_sense   = sense_ctrl_r;
  assign rd_enable  = {ch_en, 6'h00};
  assign rd_flags   = {flags_view, 6'h00};
  assign rd_core    = core_ctrl_r;
  assign rd_status  = {6'h00, evt_status_r};
  assign rd_mask    = {6'h00, evt_mask_r};
  assign rd_pins    = {pin_oe, pin_drv, 2'h0, sync2_r};

  // Some enabled level channel has its pin low, as the wake sampler sees it.
  assign wake_cand = |(level_mode & ch_en & ~wk_s2_r);

  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      epi_pkg::ADDR_SENSE_CTRL: rdata_nxt = rd_sense;
      epi_pkg::ADDR_IRQ_ENABLE: rdata_nxt = rd_enable;
      epi_pkg::ADDR_IRQ_FLAGS:  rdata_nxt = rd_flags;
      epi_pkg::ADDR_CORE_CTRL:  rdata_nxt = rd_core;
      epi_pkg::ADDR_EVT_STATUS: rdata_nxt = rd_status;
      epi_pkg::ADDR_EVT_MASK:   rdata_nxt = rd_mask;
      epi_pkg::ADDR_PIN_STATE:  rdata_nxt = rd_pins;
      default:                  rdata_nxt = 8'h00;
    endcase
  end
  assign reg_rdata = rdata_r;

  // Pin synchroniser on the I/O clock. Only the second stage feeds any logic.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 2'h3;
      sync2_r <= 2'h3;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  // Previous sample. It resets to the idle high level, so no false edge follows reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= 2'h3;
    end else begin
      prev_r <= sync2_r;
    end
  end

  // Sense control.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sense_ctrl_r <= epi_pkg::SENSE_CTRL_RST;
    end else if (wr_sense) begin
      sense_ctrl_r <= reg_wdata;
    end
  end

  // Channel enables; only the two enable bits are stored.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_enable_r <= epi_pkg::IRQ_ENABLE_RST;
    end else if (wr_enable) begin
      irq_enable_r <= reg_wdata & 8'hc0;
    end
  end

  // Core control; bit 0 is the global interrupt enable.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_ctrl_r <= epi_pkg::CORE_CTRL_RST;
    end else if (wr_core) begin
      core_ctrl_r <= reg_wdata;
    end
  end

  // Event mask.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_mask_r <= epi_pkg::EVT_MASK_RST[1:0];
    end else if (wr_mask) begin
      evt_mask_r <= reg_wdata[1:0];
    end
  end

  // Pin drive value, used when software forces an interrupt through the pad.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_drv <= 2'h0;
    end else if (wr_pin) begin
      pin_drv <= reg_wdata[5:4];
    end
  end

  // Pin output enable.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_oe <= 2'h0;
    end else if (wr_pin) begin
      pin_oe <= reg_wdata[7:6];
    end
  end

  // Pending flags.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= epi_pkg::IRQ_FLAGS_RST[7:6];
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Event status.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_status_r <= 2'h0;
    end else begin
      evt_status_r <= evt_status_nxt;
    end
  end

  // Read data stands for the one cycle after the read strobe and is zero otherwise.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

  // Wake synchroniser. The I/O path may be stopped, so the sampler has its own pair.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wk_s1_r <= 2'h3;
      wk_s2_r <= 2'h3;
    end else begin
      wk_s1_r <= pin_raw;
      wk_s2_r <= wk_s1_r;
    end
  end

  // Wake sampler state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wk_state_r <= epi_pkg::EPI_WK_IDLE;
    end else begin
      wk_state_r <= wk_state_nxt;
    end
  end

  // Start-up counter in watchdog ticks.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wk_cnt_r <= 8'h00;
    end else begin
      wk_cnt_r <= wk_cnt_nxt;
    end
  end

  // Wake pulse, one cycle long.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= wake_nxt;
    end
  end

  // Two ticks must both see an enabled low level before start-up begins, which filters noise.
  always_comb begin
    wk_state_nxt = wk_state_r;
    wk_cnt_nxt   = wk_cnt_r;
    wake_nxt     = 1'b0;
    case (wk_state_r)
      epi_pkg::EPI_WK_IDLE: begin
        if (power_down && wdt_tick && wake_cand) begin
          wk_state_nxt = epi_pkg::EPI_WK_SAMPLE2;
        end
      end
      epi_pkg::EPI_WK_SAMPLE2: begin
        if (wdt_tick && wake_cand) begin
          wk_state_nxt = epi_pkg::EPI_WK_STARTUP;
          wk_cnt_nxt   = epi_pkg::STARTUP_TICKS;
        end else if (wdt_tick) begin
          wk_state_nxt = epi_pkg::EPI_WK_IDLE;
        end
      end
      epi_pkg::EPI_WK_STARTUP: begin
        if (wdt_tick && wk_cnt_r != 8'h00) begin
          wk_cnt_nxt = wk_cnt_r - 8'h01;
        end
        if (wk_cnt_r == 8'h00) begin
          // Wake completes even if the level has gone; the level path then raises no request.
          wake_nxt     = 1'b1;
          wk_state_nxt = epi_pkg::EPI_WK_IDLE;
        end
      end
      default: begin
        wk_state_nxt = epi_pkg::EPI_WK_IDLE;
      end
    endcase
  end

endmodule

// ### test/epi_unit_chk.sv
// Port checker for the external pin interrupt unit.
`timescale 1ns/1ps
module epi_unit_chk (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst,
  // Pins.
  input wire logic       ext_irq0_line_i,
  input wire logic       ext_irq1_line_i,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Core side.
  input wire logic       irq0_req,
  input wire logic       irq1_req,
  input wire logic       irq0_ack,
  input wire logic       irq1_ack,
  input wire logic       wake_up,
  input wire logic       irq
);
  logic [3:0] sense_r;
  logic [1:0] en_r;
  logic       gie_r;
  // Shadow copies of the control registers, so requests can be judged at the ports alone.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sense_r <= 4'h0;
      en_r    <= 2'h0;
      gie_r   <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == epi_pkg::ADDR_SENSE_CTRL)
        sense_r <= reg_wdata[3:0];
      if (reg_addr == epi_pkg::ADDR_IRQ_ENABLE)
        en_r <= reg_wdata[7:6];
      if (reg_addr == epi_pkg::ADDR_CORE_CTRL)
        gie_r <= reg_wdata[0];
    end
  end
  wire on0   = en_r[0] && gie_r;
  wire on1   = en_r[1] && gie_r;
  wire low0  = sense_r[1:0] == 2'h0;
  wire lvl0  = on0 && low0;
  wire fall0 = on0 && sense_r[1:0] == 2'h2 && !irq0_ack && !reg_wr;
  wire rise1 = on1 && sense_r[3:2] == 2'h3 && !irq1_ack && !reg_wr;
  logic fl_rd;
  // Marks the cycle in which the flag register read data stands.
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      fl_rd <= 1'b0;
    else
      fl_rd <= reg_rd && reg_addr == epi_pkg::ADDR_IRQ_FLAGS;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");
  flag_bits_a: assert property (fl_rd |-> reg_rdata[5:0] == 6'h00) else $error("flag spare bits set");
  lvl_flag_a: assert property (fl_rd && $past(low0) |-> !reg_rdata[6]) else $error("level flag set");
  req_gate_a: assert property ((on0 || !irq0_req) && (on1 || !irq1_req)) else $error("ungated request");
  lvl_req_a: assert property ((!ext_irq0_line_i && lvl0) [*3] |-> irq0_req) else $error("level lost");
  lvl_off_a: assert property ((ext_irq0_line_i && lvl0) [*3] |-> !irq0_req) else $error("level stuck");
  fall_req_a: assert property (ext_irq0_line_i [*2] ##1 (!ext_irq0_line_i && fall0) [*4] |-> irq0_req)
    else $error("fall missed");
  rise_req_a: assert property (!ext_irq1_line_i [*2] ##1 (ext_irq1_line_i && rise1) [*4] |-> irq1_req)
    else $error("rise missed");
  wake_pulse_a: assert property (wake_up |=> !wake_up) else $error("wake not a pulse");
  cover property (wake_up);
  cover property (irq);
  cover property (irq0_req && irq1_req == 1'b0);
endmodule
bind epi_unit epi_unit_chk u_chk (.*);

// ### test/epi_src.sv
// Model of the outside sources that pull the two interrupt pins.
`timescale 1ns/1ps
module epi_src (
  // Source levels; high means released to the pull-up.
  input  wire logic src_lvl0,
  input  wire logic src_lvl1,
  // Drive from the unit.
  input  wire logic ext_irq0_line_o,
  input  wire logic ext_irq0_line_oe,
  input  wire logic ext_irq1_line_o,
  input  wire logic ext_irq1_line_oe,
  // Resolved pin levels.
  output logic      ext_irq0_line_i,
  output logic      ext_irq1_line_i
);
  // A source holds its level until told otherwise; the unit's drive wins while its output enable is set.
  assign ext_irq0_line_i = ext_irq0_line_oe ? ext_irq0_line_o : src_lvl0;
  assign ext_irq1_line_i = ext_irq1_line_oe ? ext_irq1_line_o : src_lvl1;
endmodule

// ### test/test_external_pin_interrupt_unit.sv
// Self-checking bench for the external pin interrupt unit.
`timescale 1ns/1ps
module test_external_pin_interrupt_unit;
  logic       clk, rst, wdt_tick, power_down, src_lvl0, src_lvl1, reg_wr, reg_rd;
  logic       ext_irq0_line_i, ext_irq0_line_o, ext_irq0_line_oe, irq0_req, irq0_ack;
  logic       ext_irq1_line_i, ext_irq1_line_o, ext_irq1_line_oe, irq1_req, irq1_ack;
  logic       wake_up, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, r;
  int         fails, n_checks, cyc, wakes;
  epi_unit dut (.*);
  epi_src src (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc++;
    if (wake_up === 1'b1)
      wakes++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report;
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // One-cycle strobe: 0 and 1 acknowledge a vector entry, 2 is a watchdog tick.
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) irq0_ack <= 1'b1;
    else if (k == 1) irq1_ack <= 1'b1;
    else wdt_tick <= 1'b1;
    @(posedge clk);
    {irq0_ack, irq1_ack, wdt_tick} <= 3'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic pin(input int ch, input logic v);
    @(posedge clk);
    if (ch == 0) src_lvl0 <= v;
    else src_lvl1 <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  function automatic logic fl(input int m, input logic fall);
    return m == 1 || (m == 2 && fall) || (m == 3 && !fall);
  endfunction
  initial begin
    {rst, wdt_tick, power_down, reg_wr, reg_rd, irq0_ack, irq1_ack} = 7'h40;
    {src_lvl0, src_lvl1, reg_addr, reg_wdata} = 14'h3000;
    r = $urandom(32'h67d1f36d);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) rd(a[3:0], a == 6 ? 8'h03 : 8'h00);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'hc0);
    wr(4'h3, 8'h01);
    wr(4'h5, 8'h03);
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 4; m++) begin
        r = {4'h0, 4'($urandom)};
        if (ch == 0) r[1:0] = m[1:0];
        else r[3:2] = m[1:0];
        wr(4'h0, r);
        rd(4'h0, r);
        pin(ch, 1'b0);
        chk(ch ? irq1_req : irq0_req, m == 0 || fl(m, 1'b1));
        chk(irq, m != 3);
        rd(4'h2, {7'h00, fl(m, 1'b1)} << (6 + ch));
        if (m[0]) wr(4'h2, 8'h40 << ch);
        else pulse(ch);
        pin(ch, 1'b1);
        chk(ch ? irq1_req : irq0_req, fl(m, 1'b0));
        rd(4'h2, {7'h00, fl(m, 1'b0)} << (6 + ch));
        wr(4'h2, 8'hc0);
        wr(4'h4, 8'h03);
        chk(irq, 1'b0);
      end
    end
    // Drive the pin from the unit itself with the global enable and event mask off.
    wr(4'h0, 8'h02);
    wr(4'h3, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h40);
    pin(0, 1'b1);
    chk({ext_irq1_line_oe, ext_irq1_line_o, ext_irq0_line_oe, ext_irq0_line_o, irq0_req, irq}, 8'h08);
    rd(4'h6, 8'h42);
    rd(4'h2, 8'h40);
    wr(4'h5, 8'h01);
    chk(irq, 1'b1);
    wr(4'h3, 8'h01);
    chk(irq0_req, 1'b1);
    wr(4'h6, 8'h00);
    pulse(0);
    wr(4'h4, 8'h03);
    chk({irq0_req, irq}, 8'h00);
    wr(4'h0, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wakes = 0;
      @(posedge clk);
      power_down <= 1'b1;
      pin(0, 1'b0);
      repeat (2) pulse(2);
      if (k == 1) pin(0, 1'b1);
      repeat (5) pulse(2);
      chk(wakes[7:0], 8'h01);
      chk(irq0_req, k == 0);
      pin(0, 1'b1);
      power_down <= 1'b0;
      pulse(2);
    end
    final_report();
  end
endmodule
